// ===== common/idmac_pkg.sv
package idmac_pkg;
    // flow control device numbering
    localparam int IDMAC_NUM_REQ = 12;
    localparam logic [3:0] IDMAC_SEL_FIRST_SPI = 4'h8;
    localparam logic [3:0] IDMAC_SEL_LAST = 4'hB;
    // packet size codes: bytes = 1 << code
    localparam logic [1:0] IDMAC_SIZE_1 = 2'h0;
    localparam logic [1:0] IDMAC_SIZE_2 = 2'h1;
    localparam logic [1:0] IDMAC_SIZE_4 = 2'h2;
    localparam int IDMAC_ADDR_W = 32;
    localparam int IDMAC_DATA_W = 32;
    localparam int IDMAC_FIFO_DEPTH = 16;
    localparam int IDMAC_DONE_CYCLES = 1;
    // reset values
    localparam logic [31:0] IDMAC_ADDR_RST = 32'h0000_0000;
    localparam logic [1:0] IDMAC_STATE_RST = 2'h0;
    // channel states, gray along idle-read-write-finish
    typedef enum logic [1:0] {
        IDMAC_IDLE = 2'b00,
        IDMAC_READ = 2'b01,
        IDMAC_WRITE = 2'b11,
        IDMAC_FINISH = 2'b10
    } idmac_state_t;
endpackage

// ===== rtl/idmac_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module idmac_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // handshakes
    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_ff];

    // storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // idmac_fifo
`default_nettype wire

// ===== rtl/idmac_req_sel.sv
`timescale 1ns/1ps
`default_nettype none
module idmac_req_sel
    import idmac_pkg::*;
#(
    parameter int NREQ = IDMAC_NUM_REQ
) (
    // selection
    input wire logic [3:0] sel,
    // request lines
    input wire logic [NREQ-1:0] req_in,
    input wire logic [NREQ-1:0] term_in,
    // selected lines
    output logic req_out,
    output logic term_out,
    output logic sel_valid,
    output logic term_supported
);
    // one requester per device number
    always_comb begin
        req_out = 1'b0;
        term_out = 1'b0;
        sel_valid = (sel <= IDMAC_SEL_LAST);
        term_supported = (sel < IDMAC_SEL_FIRST_SPI);
        for (int i = 0; i < NREQ; i++) begin
            if (sel == 4'(i)) begin
                req_out = req_in[i];
                term_out = term_in[i] && term_supported;
            end
        end
    end
endmodule // idmac_req_sel
`default_nettype wire

// ===== rtl/idmac_channel.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - packets are 1, 2 or 4 bytes, only sizes the devices support.
// - channel paced by firmware or hardware per its flow control mode.
// - source and destination addresses are 32 bits wide.
// - transfer ends on master terminate, firmware abort or limit.
// - a transfer is one packet or several consecutive packets.
// - packet size never exceeds what both ends support.
// - bytes read per packet equal bytes written per packet.
// - every packet is carried from read to write completely.
// - any of the requesters may be assigned to the channel.
// - the master device decides when the channel is active.
// - firmware is master in firmware mode, peripheral in hardware mode.
// - device select field indexes the flow control port of the master.
// - slave device is whoever owns the programmed target address.
// - either master or slave side may be source; direction selectable.
// - select 0..7 are serial bus sides, 8..11 serial peripheral sides.
// - no terminate or done for serial peripheral requesters.
module idmac_channel
    import idmac_pkg::*;
#(
    parameter int NREQ = IDMAC_NUM_REQ,
    parameter int FIFO_DEPTH = IDMAC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // channel setup from firmware
    input wire logic cfg_hw_flow,
    input wire logic [3:0] cfg_dev_sel,
    input wire logic cfg_to_slave,
    input wire logic [1:0] cfg_size,
    input wire logic [1:0] cfg_max_size,
    input wire logic cfg_incr_master,
    input wire logic cfg_incr_slave,
    input wire logic [31:0] cfg_master_addr,
    input wire logic [31:0] cfg_slave_addr,
    input wire logic [31:0] cfg_slave_end,
    input wire logic cfg_start,
    input wire logic cfg_abort,
    input wire logic cfg_fw_go,
    // flow control ports
    input wire logic [NREQ-1:0] hw_req,
    input wire logic [NREQ-1:0] hw_term,
    output logic [NREQ-1:0] hw_finished,
    // memory read port
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [31:0] rd_addr,
    output logic [1:0] rd_size,
    input wire logic rd_resp_valid,
    input wire logic [31:0] rd_resp_data,
    // memory write port
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [31:0] wr_addr,
    output logic [1:0] wr_size,
    output logic [31:0] wr_data,
    // status
    output logic busy,
    output logic [31:0] cur_slave_addr
);
    localparam int FW = IDMAC_DATA_W + 2;
    idmac_state_t state_ff;
    idmac_state_t nxt_state;
    logic [31:0] src_addr_ff;
    logic [31:0] dst_addr_ff;
    logic stop_ff;
    logic [31:0] s_addr_ff;
    logic [31:0] s_end_ff;
    logic [1:0] size_ff;
    logic [3:0] sel_ff;
    logic hw_ff;
    logic to_slave_ff;
    logic inc_m_ff;
    logic inc_s_ff;
    logic rd_pend_ff;
    logic rd_valid_ff;
    logic wr_valid_ff;
    logic [31:0] rd_addr_ff;
    logic [31:0] wr_addr_ff;
    logic [31:0] wr_data_ff;
    logic [1:0] wr_size_ff;
    logic [NREQ-1:0] fin_ff;
    logic req_ff;
    logic busy_ff;
    logic sel_req;
    logic sel_term;
    logic sel_ok;
    logic term_ok;
    logic pace;
    logic at_limit;
    logic end_now;
    logic [31:0] step;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [FW-1:0] f_out_data;

    // clamp size to what both ends take, 4 bytes at most
    function automatic logic [1:0] clamp_size(input logic [1:0] want, input logic [1:0] cap);
        logic [1:0] lim;
        lim = (cap > IDMAC_SIZE_4) ? IDMAC_SIZE_4 : cap;
        clamp_size = (want > lim) ? lim : want;
    endfunction

    // bytes per packet
    function automatic logic [31:0] size_bytes(input logic [1:0] code);
        size_bytes = 32'h0000_0001 << code;
    endfunction

    // master selection by device number
    idmac_req_sel #(.NREQ(NREQ)) u_sel (
        .sel(sel_ff),
        .req_in(hw_req),
        .term_in(hw_term),
        .req_out(sel_req),
        .term_out(sel_term),
        .sel_valid(sel_ok),
        .term_supported(term_ok)
    );

    // read data waits here for the write side
    idmac_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(rd_resp_valid),
        .in_ready(f_in_ready),
        .in_data({size_ff, rd_resp_data}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // pacing: firmware go or a fresh hardware request edge
    assign pace = hw_ff ? (sel_req && !req_ff && sel_ok) : cfg_fw_go;
    assign step = size_bytes(size_ff);
    assign at_limit = (s_addr_ff >= s_end_ff);
    assign end_now = stop_ff || cfg_abort || (hw_ff && sel_term) || at_limit;
    assign f_out_ready = !wr_valid_ff || wr_ready;

    // state sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IDMAC_IDLE: begin
                if (cfg_start) begin
                    nxt_state = IDMAC_READ;
                end
            end
            IDMAC_READ: begin
                if (end_now && !rd_pend_ff && !rd_valid_ff) begin
                    nxt_state = IDMAC_WRITE;
                end
            end
            IDMAC_WRITE: begin
                if (!f_out_valid && !wr_valid_ff) begin
                    nxt_state = IDMAC_FINISH;
                end
            end
            IDMAC_FINISH: begin
                nxt_state = IDMAC_IDLE;
            end
            default: begin
                nxt_state = IDMAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= IDMAC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // capture setup at start
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hw_ff <= 1'b0;
            sel_ff <= 4'h0;
            to_slave_ff <= 1'b0;
            size_ff <= IDMAC_SIZE_1;
            inc_m_ff <= 1'b0;
            inc_s_ff <= 1'b0;
            s_end_ff <= IDMAC_ADDR_RST;
        end else if (state_ff == IDMAC_IDLE && cfg_start) begin
            hw_ff <= cfg_hw_flow;
            sel_ff <= cfg_dev_sel;
            to_slave_ff <= cfg_to_slave;
            size_ff <= clamp_size(cfg_size, cfg_max_size);
            inc_m_ff <= cfg_incr_master;
            inc_s_ff <= cfg_incr_slave;
            s_end_ff <= cfg_slave_end;
        end
    end

    // end request held so a short terminate during a pending read is not lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stop_ff <= 1'b0;
        end else if (state_ff == IDMAC_IDLE) begin
            stop_ff <= 1'b0;
        end else if (cfg_abort || (hw_ff && sel_term)) begin
            stop_ff <= 1'b1;
        end
    end

    // request edge tracking
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= sel_req;
        end
    end

    // read issue, one packet per pace event, addresses advance
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            src_addr_ff <= IDMAC_ADDR_RST;
            s_addr_ff <= IDMAC_ADDR_RST;
            rd_valid_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= IDMAC_ADDR_RST;
        end else if (state_ff == IDMAC_IDLE) begin
            rd_valid_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            if (cfg_start) begin
                src_addr_ff <= cfg_to_slave ? cfg_master_addr : cfg_slave_addr;
                s_addr_ff <= cfg_slave_addr;
            end
        end else begin
            if (rd_valid_ff && rd_ready) begin
                rd_valid_ff <= 1'b0;
            end else if (state_ff == IDMAC_READ && !rd_valid_ff && !rd_pend_ff && !end_now && pace && f_in_ready) begin
                rd_valid_ff <= 1'b1;
                rd_addr_ff <= src_addr_ff;
            end
            if (rd_valid_ff && rd_ready) begin
                rd_pend_ff <= 1'b1;
            end else if (rd_resp_valid) begin
                rd_pend_ff <= 1'b0;
            end
            if (rd_resp_valid) begin
                if (to_slave_ff ? inc_m_ff : inc_s_ff) begin
                    src_addr_ff <= src_addr_ff + step;
                end
                s_addr_ff <= s_addr_ff + step; // limit counts packets even on fixed slave
            end
        end
    end

    // write side drains the fifo with matching size
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_valid_ff <= 1'b0;
            wr_addr_ff <= IDMAC_ADDR_RST;
            wr_data_ff <= 32'h0000_0000;
            wr_size_ff <= IDMAC_SIZE_1;
            dst_addr_ff <= IDMAC_ADDR_RST;
        end else begin
            // destination keeps its own pointer; the fifo may hold packets ahead of it
            if (state_ff == IDMAC_IDLE && cfg_start) begin
                dst_addr_ff <= cfg_to_slave ? cfg_slave_addr : cfg_master_addr;
            end
            if (f_out_ready) begin
                wr_valid_ff <= f_out_valid;
                if (f_out_valid) begin
                    wr_data_ff <= f_out_data[31:0];
                    wr_size_ff <= f_out_data[FW-1:FW-2];
                    wr_addr_ff <= dst_addr_ff;
                    if (to_slave_ff ? inc_s_ff : inc_m_ff) begin
                        dst_addr_ff <= dst_addr_ff + step;
                    end
                end
            end
        end
    end

    // done pulse toward the selected master
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fin_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != IDMAC_IDLE);
            for (int i = 0; i < NREQ; i++) begin
                fin_ff[i] <= (state_ff == IDMAC_FINISH) && hw_ff && term_ok && (sel_ff == 4'(i));
            end
        end
    end

    assign rd_valid = rd_valid_ff;
    assign rd_addr = rd_addr_ff;
    assign rd_size = size_ff;
    assign wr_valid = wr_valid_ff;
    assign wr_addr = wr_addr_ff;
    assign wr_size = wr_size_ff;
    assign wr_data = wr_data_ff;
    assign hw_finished = fin_ff;
    assign busy = busy_ff;
    assign cur_slave_addr = s_addr_ff;

    // size stays within 4 bytes
    property p_size_legal;
        @(posedge sys_clk) disable iff (srst) rd_valid |-> (rd_size <= IDMAC_SIZE_4);
    endproperty
    a_size_legal: assert property (p_size_legal) else $error("packet size over 4 bytes");

    // size within both ends' cap
    property p_size_cap;
        @(posedge sys_clk) disable iff (srst) (state_ff == IDMAC_IDLE && cfg_start) |=>
            (size_ff <= $past(cfg_size)) && (size_ff <= $past(cfg_max_size) || size_ff == IDMAC_SIZE_4);
    endproperty
    a_size_cap: assert property (p_size_cap) else $error("size above device cap");

    // write size matches read size
    property p_same_bytes;
        @(posedge sys_clk) disable iff (srst) wr_valid |-> (wr_size == size_ff);
    endproperty
    a_same_bytes: assert property (p_same_bytes) else $error("write size differs from read");

    // abort leaves read state within a bound
    property p_abort_ends;
        @(posedge sys_clk) disable iff (srst) (state_ff == IDMAC_READ && cfg_abort && !rd_valid_ff && !rd_pend_ff) |=> (state_ff == IDMAC_WRITE);
    endproperty
    a_abort_ends: assert property (p_abort_ends) else $error("abort did not end transfer");

    // finish then idle
    property p_finish_idle;
        @(posedge sys_clk) disable iff (srst) (state_ff == IDMAC_FINISH) |=> (state_ff == IDMAC_IDLE);
    endproperty
    a_finish_idle: assert property (p_finish_idle) else $error("finish did not return to idle");

    // done only after finish
    property p_done_cause;
        @(posedge sys_clk) disable iff (srst) (hw_finished != '0) |-> $past(state_ff) == IDMAC_FINISH;
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without finish");

    // no done to serial peripheral requesters
    property p_no_spi_done;
        @(posedge sys_clk) disable iff (srst) hw_finished[NREQ-1:8] == '0;
    endproperty
    a_no_spi_done: assert property (p_no_spi_done) else $error("done to unsupported requester");

    // hardware read only after a request edge
    property p_hw_paced;
        @(posedge sys_clk) disable iff (srst) (hw_ff && $rose(rd_valid)) |-> $past(sel_req) && !$past(req_ff);
    endproperty
    a_hw_paced: assert property (p_hw_paced) else $error("read without request");

    // every accepted packet is written before finish
    property p_drain;
        @(posedge sys_clk) disable iff (srst) (state_ff == IDMAC_FINISH) |-> !f_out_valid && !wr_valid;
    endproperty
    a_drain: assert property (p_drain) else $error("packet lost at finish");
endmodule // idmac_channel
`default_nettype wire

// ===== test/idmac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module idmac_mem_model #(
    parameter logic [31:0] SALT = 32'h5A3C_96E1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // pacing
    input wire logic slow,
    // read side
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [31:0] rd_addr,
    output logic rd_resp_valid,
    output logic [31:0] rd_resp_data,
    // write side
    output logic wr_ready
);
    logic [2:0] tick_ff;
    logic pend_ff;
    logic [31:0] addr_ff;
    // free running stall pattern
    always_ff @(posedge sys_clk) begin
        tick_ff <= srst ? 3'h0 : tick_ff + 3'h1;
    end
    // one read in flight; stall on the pattern when slow
    assign rd_ready = rd_valid && !pend_ff && (!slow || tick_ff[1:0] == 2'h0);
    assign wr_ready = !slow || tick_ff[0];
    // one beat per read; data toggles while no beat is shown
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend_ff <= 1'b0;
            rd_resp_valid <= 1'b0;
            rd_resp_data <= 32'h0;
        end else begin
            rd_resp_valid <= 1'b0;
            rd_resp_data <= ~rd_resp_data;
            if (rd_valid && rd_ready) begin
                pend_ff <= 1'b1;
                addr_ff <= rd_addr;
            end else if (pend_ff && (!slow || tick_ff[2])) begin
                rd_resp_valid <= 1'b1;
                rd_resp_data <= addr_ff ^ SALT;
                pend_ff <= 1'b0;
            end
        end
    end
endmodule // idmac_mem_model
`default_nettype wire

// ===== test/test_internal_dma_channel_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_internal_dma_channel_core;
    import idmac_pkg::*;
    localparam logic [31:0] SALT = 32'h5A3C_96E1;
    logic sys_clk, srst, slow, busy;
    logic cfg_hw_flow, cfg_to_slave, cfg_incr_master, cfg_incr_slave, cfg_start, cfg_abort, cfg_fw_go;
    logic [3:0] cfg_dev_sel;
    logic [1:0] cfg_size, cfg_max_size, rd_size, wr_size, eff;
    logic [31:0] cfg_master_addr, cfg_slave_addr, cfg_slave_end, rd_addr, rd_resp_data, wr_addr, wr_data;
    logic [31:0] cur_slave_addr, mask;
    logic [11:0] hw_req, hw_term, hw_finished, fin_seen;
    logic rd_valid, rd_ready, rd_resp_valid, wr_valid, wr_ready;
    logic [31:0] q_rd[$];
    logic [31:0] q_wr[$];
    logic [15:0] lfsr;
    int bad_count, tests_run, rd_cnt;

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    idmac_channel u_dut (.sys_clk(sys_clk), .srst(srst), .cfg_hw_flow(cfg_hw_flow), .cfg_dev_sel(cfg_dev_sel),
        .cfg_to_slave(cfg_to_slave), .cfg_size(cfg_size), .cfg_max_size(cfg_max_size),
        .cfg_incr_master(cfg_incr_master), .cfg_incr_slave(cfg_incr_slave), .cfg_master_addr(cfg_master_addr),
        .cfg_slave_addr(cfg_slave_addr), .cfg_slave_end(cfg_slave_end), .cfg_start(cfg_start),
        .cfg_abort(cfg_abort), .cfg_fw_go(cfg_fw_go), .hw_req(hw_req), .hw_term(hw_term),
        .hw_finished(hw_finished), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
        .rd_size(rd_size), .rd_resp_valid(rd_resp_valid), .rd_resp_data(rd_resp_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_size(wr_size), .wr_data(wr_data), .busy(busy),
        .cur_slave_addr(cur_slave_addr));

    idmac_mem_model #(.SALT(SALT)) u_mem (.sys_clk(sys_clk), .srst(srst), .slow(slow), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_resp_valid(rd_resp_valid), .rd_resp_data(rd_resp_data),
        .wr_ready(wr_ready));

    // comparison and verdict
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rnd32(output logic [31:0] v);
        lfsr = lfsr_next(lfsr);
        v[31:16] = {4'h0, lfsr[11:0]};
        lfsr = lfsr_next(lfsr);
        v[15:0] = lfsr;
    endtask

    // set up a channel, start it, check it stays quiet until paced
    task automatic go(input logic hw, input logic [3:0] dev, input logic dir, input logic [1:0] sz,
                      input logic [1:0] cap, input int n);
        rnd32(cfg_master_addr);
        rnd32(cfg_slave_addr);
        eff = (sz < cap) ? sz : cap;
        mask = 32'hFFFF_FFFF >> (32 - (8 << eff));
        cfg_slave_end = cfg_slave_addr + 32'(n << eff);
        cfg_hw_flow = hw;
        cfg_dev_sel = dev;
        cfg_to_slave = dir;
        cfg_size = sz;
        cfg_max_size = cap;
        fin_seen = '0;
        rd_cnt = 0;
        cfg_start = 1'b1;
        tick();
        cfg_start = 1'b0;
        hw_req = lfsr[11:0] & ~(12'h001 << dev);
        tick();
        cmp("busy_start", 32'h1, 32'(busy));
        repeat (8) tick();
        hw_req = '0;
        cmp("idle_reads", 32'h0, 32'(rd_cnt));
    endtask

    // note one packet's expectation, pace it, wait for its write
    task automatic pace(input int k);
        int w;
        logic [31:0] off, soff, doff;
        off = 32'(k << eff);
        soff = (cfg_to_slave ? cfg_incr_master : cfg_incr_slave) ? off : 32'h0;
        doff = (cfg_to_slave ? cfg_incr_slave : cfg_incr_master) ? off : 32'h0;
        q_rd.push_back(((cfg_to_slave ? cfg_master_addr : cfg_slave_addr) + soff) ^ SALT);
        q_wr.push_back((cfg_to_slave ? cfg_slave_addr : cfg_master_addr) + doff);
        if (cfg_hw_flow) hw_req[cfg_dev_sel] = 1'b1;
        else cfg_fw_go = 1'b1;
        tick();
        hw_req = '0;
        cfg_fw_go = 1'b0;
        w = 0;
        while (q_wr.size() != 0 && w < 300) begin
            tick();
            w++;
        end
        cmp("write_seen", 32'h0, 32'(q_wr.size()));
    endtask

    // wait for the channel to end and check how it ended
    task automatic ending(input logic lim, input logic [11:0] fin);
        int w;
        w = 0;
        while (busy !== 1'b0 && w < 200) begin
            tick();
            w++;
        end
        tick();
        tick();
        cmp("busy_end", 32'h0, 32'(busy));
        cmp("finished", 32'(fin), 32'(fin_seen));
        if (lim) cmp("slave_addr", cfg_slave_end, cur_slave_addr);
        cmp("spare_writes", 32'h0, 32'(q_wr.size()));
    endtask

    // watch the memory ports and the finished lines
    always @(posedge sys_clk) begin
        if (!srst) begin
            if (rd_valid && rd_ready) begin
                rd_cnt++;
                cmp("rd_size", 32'(eff), 32'(rd_size));
            end
            if (wr_valid && wr_ready) begin
                if (q_wr.size() == 0) cmp("wr_extra", 32'h0, 32'h1);
                else begin
                    cmp("wr_addr", q_wr.pop_front(), wr_addr);
                    cmp("wr_size", 32'(eff), 32'(wr_size));
                    cmp("wr_data", q_rd.pop_front() & mask, wr_data & mask);
                end
            end
            fin_seen = fin_seen | hw_finished;
        end
    end

    // main sequence
    initial begin
        lfsr = 16'hBD73;
        {srst, slow, cfg_hw_flow, cfg_to_slave, cfg_start, cfg_abort, cfg_fw_go} = 7'h40;
        {cfg_incr_master, cfg_incr_slave} = 2'h3;
        {cfg_dev_sel, cfg_size, cfg_max_size, hw_req, hw_term} = '0;
        {cfg_master_addr, cfg_slave_addr, cfg_slave_end} = '0;
        repeat (6) tick();
        srst = 1'b0;
        go(1'b0, 4'h0, 1'b1, IDMAC_SIZE_4, IDMAC_SIZE_2, 4);
        for (int k = 0; k < 4; k++) pace(k);
        ending(1'b1, 12'h000);
        // every requester, all sizes, both directions
        for (int d = 0; d < IDMAC_NUM_REQ; d++) begin
            slow = d[1];
            go(1'b1, 4'(d), d[0], 2'(d % 3), IDMAC_SIZE_4, 2);
            pace(0);
            pace(1);
            ending(1'b1, (d < 8) ? 12'(1 << d) : 12'h000);
        end
        // master terminates early
        go(1'b1, 4'h5, 1'b1, IDMAC_SIZE_4, IDMAC_SIZE_4, 8);
        pace(0);
        hw_term[5] = 1'b1;
        tick();
        hw_term = '0;
        ending(1'b0, 12'h020);
        // terminate from a serial peripheral requester has no effect; fixed slave source
        cfg_incr_slave = 1'b0;
        go(1'b1, 4'h9, 1'b0, IDMAC_SIZE_1, IDMAC_SIZE_4, 2);
        pace(0);
        hw_term[9] = 1'b1;
        tick();
        hw_term = '0;
        repeat (6) tick();
        cmp("busy_term_ign", 32'h1, 32'(busy));
        pace(1);
        ending(1'b1, 12'h000);
        // firmware abort mid transfer; fixed master destination
        {cfg_incr_master, cfg_incr_slave} = 2'h1;
        go(1'b0, 4'h0, 1'b0, IDMAC_SIZE_2, IDMAC_SIZE_4, 8);
        pace(0);
        pace(1);
        cfg_abort = 1'b1;
        tick();
        cfg_abort = 1'b0;
        ending(1'b0, 12'h000);
        end_sim();
    end

    // watchdog
    initial begin
        #1000000;
        bad_count++;
        $display("[FAIL] watchdog expected end seen hang");
        end_sim();
    end
endmodule // test_internal_dma_channel_core
`default_nettype wire
